// ### design/stpw_top.sv
`include "stpw_consts.svh"

module stpw_top #(
    parameter int PIT_W = 16,
    parameter int WDG_W = 16,
    parameter int SEC_W = 20,
    parameter int SPRE_W = 16
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_CE,
    input wire logic I_SLOW_CLK,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic O_PREADY,
    output logic [31:0] O_PRDATA,
    output logic O_PSLVERR,
    output logic O_IRQ,
    output logic O_OVF_N,
    output logic O_WDOG_RST
);
    localparam logic [6:0] WDG_PRE_LAST = 7'(`STPW_WDOG_DIV - 1);
    localparam logic [3:0] EXT_CYC = 4'(`STPW_EXT_PULSE_CYCLES);
    localparam logic [31:0] RST_WDOG = `STPW_RST_WDOG;
    localparam logic [31:0] RST_SPRE = `STPW_RST_SEC_PRESCALE;
    localparam logic [31:0] RST_ALARM = `STPW_RST_ALARM;

    // slow clock sampling
    logic [2:0] slow_sync;
    logic slow_lvl;
    logic slow_tick;

    // bus slave
    stpw_pkg::stpw_bus_state_t bus_state;
    logic bus_done;
    logic wr_done;
    logic rd_flags_done;
    logic addr_hit;
    logic [31:0] next_rdata;

    // register file
    logic [PIT_W-1:0] period_value;
    logic [WDG_W-1:0] watchdog_value;
    logic overflow_reset_enable;
    logic external_pulse_enable;
    logic [SPRE_W-1:0] secp;
    logic [SEC_W-1:0] alarm;
    stpw_pkg::stpw_flags_t flags;
    stpw_pkg::stpw_flags_t mask;

    // timers
    logic [PIT_W-1:0] pit_cnt;
    logic [WDG_W-1:0] wdg_cnt;
    logic [6:0] wdg_pre;
    logic [3:0] ext_cnt;
    logic [SPRE_W-1:0] sec_pre;
    logic [SEC_W-1:0] sec_cnt;

    logic pit_wr;
    logic wdm_wr;
    logic cr_wr;
    logic sec_wr;
    logic alm_wr;
    logic ier_wr;
    logic idr_wr;
    logic wdg_restart;
    logic pit_evt;
    logic wdg_ovf;
    logic sec_adv;
    logic alarm_evt;
    stpw_pkg::stpw_flags_t flag_set;
    stpw_pkg::stpw_flags_t flag_clr;

    // slow clock edge: change accepted when stages two and three agree
    // slow clock tick
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            slow_sync <= 3'h0;
            slow_lvl <= 1'b0;
            slow_tick <= 1'b0;
        end else if (I_CE) begin
            slow_sync <= {slow_sync[1:0], I_SLOW_CLK};
            if (slow_sync[1] == slow_sync[2]) begin
                slow_lvl <= slow_sync[2];
            end
            slow_tick <= (slow_sync[1] == slow_sync[2]) && slow_sync[2] && !slow_lvl;
        end
    end

    // bus: access completes on the second edge after penable rises
    assign bus_done = I_PSEL && I_PENABLE && O_PREADY;
    assign wr_done = bus_done && I_PWRITE;
    assign rd_flags_done = bus_done && !I_PWRITE && (I_PADDR == `STPW_OFS_EVENT_FLAGS);
    assign pit_wr = wr_done && (I_PADDR == `STPW_OFS_PERIOD);
    assign wdm_wr = wr_done && (I_PADDR == `STPW_OFS_WDOG);
    assign cr_wr = wr_done && (I_PADDR == `STPW_OFS_RESTART_CTRL);
    assign sec_wr = wr_done && (I_PADDR == `STPW_OFS_SEC_PRESCALE);
    assign alm_wr = wr_done && (I_PADDR == `STPW_OFS_ALARM);
    assign ier_wr = wr_done && (I_PADDR == `STPW_OFS_IRQ_SET);
    assign idr_wr = wr_done && (I_PADDR == `STPW_OFS_IRQ_CLEAR);
    assign wdg_restart = cr_wr && I_PWDATA[`STPW_RESTART_BIT];

    always_comb begin
        next_rdata = 32'h00000000;
        addr_hit = 1'b1;
        unique case (I_PADDR)
            `STPW_OFS_RESTART_CTRL: next_rdata = 32'h00000000;
            `STPW_OFS_PERIOD: next_rdata[PIT_W-1:0] = period_value;
            `STPW_OFS_WDOG: begin
                next_rdata[WDG_W-1:0] = watchdog_value;
                next_rdata[`STPW_OVERFLOW_RESET_ENABLE_BIT] = overflow_reset_enable;
                next_rdata[`STPW_EXTERNAL_PULSE_ENABLE_BIT] = external_pulse_enable;
            end
            `STPW_OFS_SEC_PRESCALE: next_rdata[SPRE_W-1:0] = secp;
            `STPW_OFS_EVENT_FLAGS: next_rdata[3:0] = flags;
            `STPW_OFS_IRQ_SET: next_rdata = 32'h00000000;
            `STPW_OFS_IRQ_CLEAR: next_rdata = 32'h00000000;
            `STPW_OFS_IRQ_VIEW: next_rdata[3:0] = mask;
            `STPW_OFS_ALARM: next_rdata[SEC_W-1:0] = alarm;
            `STPW_OFS_SEC_COUNT: next_rdata[SEC_W-1:0] = sec_cnt;
            default: addr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            bus_state <= stpw_pkg::STPW_BUS_IDLE;
            O_PREADY <= 1'b0;
            O_PRDATA <= 32'h00000000;
            O_PSLVERR <= 1'b0;
        end else if (I_CE) begin
            unique case (bus_state)
                stpw_pkg::STPW_BUS_IDLE: begin
                    if (I_PSEL && I_PENABLE) begin
                        bus_state <= stpw_pkg::STPW_BUS_DONE;
                        O_PREADY <= 1'b1;
                        O_PRDATA <= I_PWRITE ? 32'h00000000 : next_rdata;
                        O_PSLVERR <= !addr_hit;
                    end
                end
                stpw_pkg::STPW_BUS_DONE: begin
                    bus_state <= stpw_pkg::STPW_BUS_IDLE;
                    O_PREADY <= 1'b0;
                    O_PSLVERR <= 1'b0;
                end
            endcase
        end
    end

    // period counter load
    // counter holds remaining ticks minus one, so value zero wraps to full range
    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            period_value <= PIT_W'(`STPW_RST_PERIOD);
            pit_cnt <= PIT_W'(`STPW_RST_PERIOD) - 1'b1;
        end else if (I_CE) begin
            if (pit_wr) begin
                period_value <= I_PWDATA[PIT_W-1:0];
                pit_cnt <= I_PWDATA[PIT_W-1:0] - 1'b1;
            end else if (slow_tick) begin
                pit_cnt <= (pit_cnt == '0) ? period_value - 1'b1 : pit_cnt - 1'b1;
            end
        end
    end

    assign pit_evt = slow_tick && (pit_cnt == '0) && !pit_wr;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            watchdog_value <= RST_WDOG[WDG_W-1:0];
            overflow_reset_enable <= RST_WDOG[`STPW_OVERFLOW_RESET_ENABLE_BIT];
            external_pulse_enable <= RST_WDOG[`STPW_EXTERNAL_PULSE_ENABLE_BIT];
        end else if (I_CE && wdm_wr) begin
            watchdog_value <= I_PWDATA[WDG_W-1:0];
            overflow_reset_enable <= I_PWDATA[`STPW_OVERFLOW_RESET_ENABLE_BIT];
            external_pulse_enable <= I_PWDATA[`STPW_EXTERNAL_PULSE_ENABLE_BIT];
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            wdg_pre <= 7'h00;
            wdg_cnt <= RST_WDOG[WDG_W-1:0] - 1'b1;
        end else if (I_CE) begin
            if (wdg_restart) begin
                wdg_pre <= 7'h00;
                wdg_cnt <= watchdog_value - 1'b1;
            end else if (slow_tick) begin
                wdg_pre <= wdg_pre + 7'h01;
                if (wdg_pre == WDG_PRE_LAST) begin
                    wdg_cnt <= (wdg_cnt == '0) ? watchdog_value - 1'b1 : wdg_cnt - 1'b1;
                end
            end
        end
    end

    assign wdg_ovf = slow_tick && (wdg_pre == WDG_PRE_LAST) && (wdg_cnt == '0) && !wdg_restart;

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            ext_cnt <= 4'h0;
            O_OVF_N <= 1'b1;
        end else if (I_CE) begin
            if (wdg_ovf && external_pulse_enable) begin
                ext_cnt <= EXT_CYC;
                O_OVF_N <= 1'b0;
            end else if (slow_tick && ext_cnt != 4'h0) begin
                ext_cnt <= ext_cnt - 4'h1;
                O_OVF_N <= (ext_cnt == 4'h1);
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_WDOG_RST <= 1'b0;
        end else if (I_CE) begin
            O_WDOG_RST <= wdg_ovf && overflow_reset_enable;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            secp <= RST_SPRE[SPRE_W-1:0];
            sec_pre <= RST_SPRE[SPRE_W-1:0] - 1'b1;
            sec_cnt <= '0;
        end else if (I_CE) begin
            if (sec_wr) begin
                secp <= I_PWDATA[SPRE_W-1:0];
                sec_pre <= I_PWDATA[SPRE_W-1:0] - 1'b1;
                sec_cnt <= '0;
            end else if (slow_tick) begin
                if (sec_pre == '0) begin
                    sec_pre <= secp - 1'b1;
                    sec_cnt <= sec_cnt + 1'b1;
                end else begin
                    sec_pre <= sec_pre - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            alarm <= RST_ALARM[SEC_W-1:0];
        end else if (I_CE && alm_wr) begin
            alarm <= I_PWDATA[SEC_W-1:0];
        end
    end

    assign sec_adv = slow_tick && (sec_pre == '0) && !sec_wr;
    // match on the value being entered
    assign alarm_evt = sec_adv && (SEC_W'(sec_cnt + 1'b1) == alarm);

    // sticky flags, set beats read clear
    // only bits actually returned by the read are cleared
    always_comb begin
        flag_set = 4'h0;
        flag_set[`STPW_FLAG_PERIOD] = pit_evt;
        flag_set[`STPW_FLAG_WDOG] = wdg_ovf;
        flag_set[`STPW_FLAG_SECINC] = sec_adv;
        flag_set[`STPW_FLAG_ALARM] = alarm_evt;
        flag_clr = rd_flags_done ? O_PRDATA[3:0] : 4'h0;
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            flags <= 4'h0;
        end else if (I_CE) begin
            flags <= (flags & ~flag_clr) | flag_set;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            mask <= 4'h0;
        end else if (I_CE) begin
            if (ier_wr) begin
                mask <= mask | I_PWDATA[3:0];
            end else if (idr_wr) begin
                mask <= mask & ~I_PWDATA[3:0];
            end
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RST_N) begin
            O_IRQ <= 1'b0;
        end else if (I_CE) begin
            O_IRQ <= |(flags & mask);
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);

    a_pit_reload: assert property (I_CE && pit_evt |=> pit_cnt == period_value - 1'b1 && flags[0])
        else $error("period counter did not reload on zero");
    a_pit_write: assert property (I_CE && pit_wr |=> pit_cnt == period_value - 1'b1)
        else $error("period write did not restart counter");
    a_wdg_hold: assert property (I_CE && wdm_wr && !slow_tick |=> $stable(wdg_cnt))
        else $error("watchdog setting write moved counter");
    a_wdg_restart: assert property (I_CE && wdg_restart |=>
        wdg_cnt == watchdog_value - 1'b1 && wdg_pre == 7'h00)
        else $error("watchdog restart did not reload");
    a_wdg_overflow: assert property (I_CE && wdg_ovf |=>
        flags[1] && wdg_cnt == watchdog_value - 1'b1)
        else $error("watchdog overflow not flagged or reloaded");
    a_ovf_pulse: assert property (I_CE && wdg_ovf && external_pulse_enable |=>
        !O_OVF_N && ext_cnt == 4'h8)
        else $error("external overflow pulse not started");
    a_ovf_quiet: assert property (I_CE && !external_pulse_enable && O_OVF_N |=> O_OVF_N)
        else $error("external overflow pulse without enable");
    a_wdg_reset: assert property (I_CE && wdg_ovf |=> O_WDOG_RST == $past(overflow_reset_enable))
        else $error("internal reset does not follow enable");
    a_sec_clear: assert property (I_CE && sec_wr |=>
        sec_cnt == '0 && sec_pre == secp - 1'b1)
        else $error("prescale write did not clear seconds");
    a_sec_flag: assert property (I_CE && sec_adv |=>
        flags[2] && sec_cnt == $past(sec_cnt) + 1'b1)
        else $error("seconds advance not flagged");
    a_mask_set: assert property (I_CE && ier_wr |=>
        mask == ($past(mask) | $past(I_PWDATA[3:0])))
        else $error("enable-set write gave wrong mask");
    a_mask_clear: assert property (I_CE && idr_wr |=>
        mask == ($past(mask) & ~$past(I_PWDATA[3:0])))
        else $error("enable-clear write gave wrong mask");
    a_irq_follow: assert property (I_CE && |(flags & mask) |=> O_IRQ)
        else $error("interrupt missing for enabled flag");
    a_irq_quiet: assert property (I_CE && !(|(flags & mask)) |=> !O_IRQ)
        else $error("interrupt without enabled flag");

    c_pit_event: cover property (I_CE && pit_evt);
    c_wdg_overflow: cover property (I_CE && wdg_ovf && external_pulse_enable);
    c_alarm_hit: cover property (I_CE && alarm_evt);
    c_flags_read: cover property (rd_flags_done && O_PRDATA[3:0] != 4'h0);
endmodule : stpw_top

// ### design/stpw_consts.svh
`ifndef STPW_CONSTS_SVH
`define STPW_CONSTS_SVH

// register byte offsets
`define STPW_OFS_RESTART_CTRL 8'h00
`define STPW_OFS_PERIOD 8'h04
`define STPW_OFS_WDOG 8'h08
`define STPW_OFS_SEC_PRESCALE 8'h0C
`define STPW_OFS_EVENT_FLAGS 8'h10
`define STPW_OFS_IRQ_SET 8'h14
`define STPW_OFS_IRQ_CLEAR 8'h18
`define STPW_OFS_IRQ_VIEW 8'h1C
`define STPW_OFS_ALARM 8'h20
`define STPW_OFS_SEC_COUNT 8'h24

// field positions
`define STPW_RESTART_BIT 0
`define STPW_OVERFLOW_RESET_ENABLE_BIT 16
`define STPW_EXTERNAL_PULSE_ENABLE_BIT 17
`define STPW_FLAG_PERIOD 0
`define STPW_FLAG_WDOG 1
`define STPW_FLAG_SECINC 2
`define STPW_FLAG_ALARM 3

// reset values
`define STPW_RST_PERIOD 32'h00000000
`define STPW_RST_WDOG 32'h00020000
`define STPW_RST_SEC_PRESCALE 32'h00008000
`define STPW_RST_ALARM 32'h00000000

// timing counts, in slow clock cycles
`define STPW_WDOG_DIV 128
`define STPW_EXT_PULSE_CYCLES 8

`endif

// ### design/stpw_pkg.sv
package stpw_pkg;
    typedef enum logic [1:0] {
        STPW_BUS_IDLE = 2'b01,
        STPW_BUS_DONE = 2'b10
    } stpw_bus_state_t;

    typedef logic [3:0] stpw_flags_t;
endpackage : stpw_pkg

// ### bench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic I_CLK = 1'h0;
    logic I_RST_N = 1'h0;
    logic I_SLOW_CLK = 1'h0;
    logic I_PSEL = 1'h0;
    logic I_PENABLE = 1'h0;
    logic I_PWRITE = 1'h0;
    logic [7:0] I_PADDR = 8'h00;
    logic [31:0] I_PWDATA = 32'h00000000;
    logic I_CE = 1'h1;
    logic O_PREADY, O_PSLVERR, O_IRQ, O_OVF_N, O_WDOG_RST, er;
    logic [31:0] O_PRDATA, rd, v;
    int err_total = 0;
    int samples_checked = 0;
    int ovf_low = 0;
    int rst_cnt = 0;
    int scnt = 0;
    int n, a, o0, r0, k;
    logic [3:0] mv;

    stpw_top uut (
        .I_CLK(I_CLK),
        .I_RST_N(I_RST_N),
        .I_CE(I_CE),
        .I_SLOW_CLK(I_SLOW_CLK),
        .I_PSEL(I_PSEL),
        .I_PENABLE(I_PENABLE),
        .I_PWRITE(I_PWRITE),
        .I_PADDR(I_PADDR),
        .I_PWDATA(I_PWDATA),
        .O_PREADY(O_PREADY),
        .O_PRDATA(O_PRDATA),
        .O_PSLVERR(O_PSLVERR),
        .O_IRQ(O_IRQ),
        .O_OVF_N(O_OVF_N),
        .O_WDOG_RST(O_WDOG_RST)
    );

    always #25 I_CLK = ~I_CLK;

    // slow clock of 10 master cycles; overflow outputs are tallied
    // periods span many cycles
    always @(posedge I_CLK) begin
        scnt <= (scnt == 4) ? 0 : scnt + 1;
        if (scnt == 4) I_SLOW_CLK <= ~I_SLOW_CLK;
        if (O_OVF_N === 1'h0) ovf_low <= ovf_low + 1;
        if (O_WDOG_RST === 1'h1) rst_cnt <= rst_cnt + 1;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    function automatic logic [31:0] mask_exp(input logic [3:0] m, input logic [3:0] s,
            input logic [3:0] c);
        return {28'h0, (m | s) & ~c};
    endfunction : mask_exp

    task automatic wt(input int c);
        repeat (c) @(posedge I_CLK);
    endtask : wt

    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int t;
        @(posedge I_CLK);
        I_PSEL <= 1'h1;
        I_PENABLE <= 1'h0;
        I_PWRITE <= w;
        I_PADDR <= ad;
        I_PWDATA <= d;
        @(posedge I_CLK);
        I_PENABLE <= 1'h1;
        t = 0;
        do begin
            @(posedge I_CLK);
            t++;
        end while (O_PREADY !== 1'h1);
        rd = O_PRDATA;
        er = O_PSLVERR;
        I_PSEL <= 1'h0;
        I_PENABLE <= 1'h0;
        check("pready wait", 32'(t), 32'h2);
    endtask : apb

    task automatic rdchk(input string nm, input logic [7:0] ad, input logic [31:0] exp);
        apb(1'h0, ad, 32'h0);
        check(nm, rd, exp);
    endtask : rdchk

    task automatic flag(input int b, input logic e);
        apb(1'h0, 8'h10, 32'h0);
        check($sformatf("flag%0d", b), 32'(rd[b]), 32'(e));
    endtask : flag

    task automatic stop_test;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge I_CLK);
        err_total++;
        stop_test();
    end

    initial begin
        void'($urandom(94538));
        n = 3 + $urandom % 6;
        a = 4 + $urandom % 5;
        mv = 4'($urandom);
        wt(5);
        I_RST_N <= 1'h1;
        rdchk("period", 8'h04, 32'h0);
        rdchk("wdog", 8'h08, 32'h00020000);
        rdchk("prescale", 8'h0C, 32'h00008000);
        rdchk("alarm", 8'h20, 32'h0);
        rdchk("mask", 8'h1C, 32'h0);
        rdchk("flags", 8'h10, 32'h0);
        rdchk("restart", 8'h00, 32'h0);
        apb(1'h1, 8'h24, 32'h00000123);
        rdchk("seconds", 8'h24, 32'h0);
        apb(1'h0, 8'h40, 32'h0);
        check("slverr", 32'(er), 32'h1);
        // period events; second write lands before the first event is due
        apb(1'h1, 8'h04, 32'(n));
        wt(n * 10 - 14);
        apb(1'h1, 8'h04, 32'(n));
        wt((n - 1) * 10 - 8);
        flag(0, 1'h0);
        wt(30);
        flag(0, 1'h1);
        wt(n * 10 + 20);
        flag(0, 1'h1);
        wt(n * 10 + 20);
        apb(1'h1, 8'h14, 32'h1);
        wt(3);
        check("irq on", 32'(O_IRQ), 32'h1);
        apb(1'h1, 8'h04, 32'h0);
        apb(1'h1, 8'h18, 32'h1);
        wt(3);
        check("irq off", 32'(O_IRQ), 32'h0);
        apb(1'h1, 8'h14, 32'(mv));
        apb(1'h1, 8'h18, 32'h5);
        rdchk("mask", 8'h1C, mask_exp(4'h0, mv, 4'h5));
        apb(1'h1, 8'h18, 32'hF);
        rdchk("mask", 8'h1C, 32'h0);
        apb(1'h0, 8'h10, 32'h0);
        // watchdog: setting write does not restart the count
        apb(1'h1, 8'h08, 32'h00030001);
        rdchk("wdog", 8'h08, 32'h00030001);
        wt(1500);
        flag(1, 1'h0);
        o0 = ovf_low;
        r0 = rst_cnt;
        apb(1'h1, 8'h00, 32'h1);
        wt(1100);
        flag(1, 1'h0);
        wt(300);
        flag(1, 1'h1);
        wt(100);
        check("ovf pulse", 32'((ovf_low - o0) inside {[70:90]}), 32'h1);
        check("wdog rst", 32'(rst_cnt - r0), 32'h1);
        apb(1'h1, 8'h08, 32'h00000001);
        o0 = ovf_low;
        r0 = rst_cnt;
        wt(1400);
        flag(1, 1'h1);
        check("ovf quiet", 32'(ovf_low - o0), 32'h0);
        check("rst quiet", 32'(rst_cnt - r0), 32'h0);
        apb(1'h1, 8'h08, 32'h0);
        apb(1'h1, 8'h00, 32'h1);
        // seconds counter and alarm
        apb(1'h1, 8'h20, 32'(a));
        apb(1'h0, 8'h10, 32'h0);
        apb(1'h1, 8'h0C, 32'h2);
        rdchk("sec clear", 8'h24, 32'h0);
        wt(a * 20 + 40);
        apb(1'h0, 8'h10, 32'h0);
        check("sec flags", 32'(rd[3:2]), 32'h3);
        k = 0;
        do begin
            apb(1'h0, 8'h24, 32'h0);
            v = rd;
            apb(1'h0, 8'h24, 32'h0);
            k++;
        end while (v !== rd && k < 5);
        check("sec count", 32'(rd inside {[a + 1:a + 3]}), 32'h1);
        // clock enable low freezes the seconds count
        v = rd;
        I_CE <= 1'h0;
        wt(100);
        I_CE <= 1'h1;
        apb(1'h0, 8'h24, 32'h0);
        check("ce freeze", 32'(rd inside {[v:v + 2]}), 32'h1);
        stop_test();
    end
endmodule : testbench
